/* rtl/power_mode_and_ext_irq_ctrl.sv */
// power mode sequencer with external interrupt pin select and sensing
// assumes cpu events are one-cycle pulses on clk_sys_in and pins are asynchronous
`timescale 1ns/100ps
`include "pwr_mode_defs.svh"

module power_mode_and_ext_irq_ctrl
    import pwr_mode_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    input wire cpu_evt_t cpu_evt_in,
    input wire halt_cfg_t halt_cfg_in,
    input wire logic other_irq_in,
    input wire logic other_halt_irq_in,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_in,
    output logic irq_mask_out,
    output logic [3:0] ext_irq_req_out,
    output logic cpu_run_out,
    output logic periph_clk_en_out,
    output logic osc_on_out,
    output logic timer_clk_en_out,
    output logic cpu_clk_en_out,
    output logic watchdog_reset_out,
    output pwr_mode_t mode_out
);

    // ==========================================================
    // registers and state
    logic [7:0] sense_reg;
    logic [7:0] pin_sel_reg;
    logic [1:0] clk_ctrl_reg;
    logic mask_reg;
    logic mask_saved_reg;
    logic [3:0] req_reg;
    // both ports are synchronised whole, {port b, port a}
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;
    logic [3:0] prev_reg;
    logic [12:0] stab_cnt_reg;
    logic [4:0] slow_cnt_reg;
    logic wdg_rst_reg;
    logic [7:0] rdata_reg;
    pwr_mode_t mode_reg;
    pwr_mode_t mode_next;

    // 2-bit mux selecting one of four pins
    function automatic logic pick4(input logic [3:0] pins, input logic [1:0] sel);
        pick4 = pins[sel];
    endfunction : pick4

    // ==========================================================
    // pin routing
    wire [1:0] line3_pin_sel = pin_sel_reg[7:6];
    wire [1:0] line2_pin_sel = pin_sel_reg[5:4];
    wire [1:0] line1_pin_sel = pin_sel_reg[3:2];
    wire [1:0] line0_pin_sel = pin_sel_reg[1:0];
    // the mux reads only synchronised pins, never the raw pads
    wire [7:0] port_a_sync = sync2_reg[7:0];
    wire [7:0] port_b_sync = sync2_reg[15:8];
    // code 11 on line 3 is unassigned; it reads as idle high
    wire ext_line_three = pick4({1'b1, port_b_sync[2:0]}, line3_pin_sel);
    wire ext_line_two = pick4(port_b_sync[6:3], line2_pin_sel);
    wire ext_line_one = pick4(port_a_sync[7:4], line1_pin_sel);
    wire ext_line_zero = pick4(port_a_sync[3:0], line0_pin_sel);
    wire [3:0] raw_lines = {ext_line_three, ext_line_two, ext_line_one, ext_line_zero};

    // pins are asynchronous: two flops before use; the detector runs on the
    // sampling clock, which is kept live in halt as a separate wake source
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            sync1_reg <= 16'hFFFF;
            sync2_reg <= 16'hFFFF;
            prev_reg <= 4'hF;
        end
        else
        begin
            sync1_reg <= {port_b_in, port_a_in};
            sync2_reg <= sync1_reg;
            prev_reg <= raw_lines;
        end
    end

    // ==========================================================
    // edge and level decode per line
    wire [3:0] rise = raw_lines & ~prev_reg;
    wire [3:0] fall = ~raw_lines & prev_reg;
    logic [3:0] edge_hit;
    logic [3:0] low_level;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_sense
            wire [1:0] line_sense = sense_reg[2*gi+1:2*gi];
            assign edge_hit[gi] = (line_sense == 2'h0) ? fall[gi] :
                                  (line_sense == 2'h1) ? rise[gi] :
                                  (line_sense == 2'h2) ? fall[gi] :
                                  (rise[gi] | fall[gi]);
            assign low_level[gi] = (line_sense == 2'h0) & ~raw_lines[gi];
        end
    endgenerate

    // request = latched edge or live low level; a set in the same cycle
    // as the service clear wins so no edge is lost
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
            req_reg <= 4'h0;
        else
            req_reg <= (req_reg & {4{~cpu_evt_in.irq_enter}}) | edge_hit;
    end
    wire [3:0] ext_req = req_reg | low_level;
    assign ext_irq_req_out = ext_req & {4{~mask_reg}};

    // line 2 on port B pin 4 is not wake capable
    wire pb4_blocked = (line2_pin_sel == 2'h1);
    wire [3:0] halt_wake_mask = {1'b1, ~pb4_blocked, 2'b11};
    wire ext_wake = |(ext_req & halt_wake_mask);
    wire any_irq = (|ext_req) | other_irq_in;
    wire halt_wake = ext_wake | other_halt_irq_in;

    // ==========================================================
    // halt decision
    wire act_halt_en = halt_cfg_in.base1_ie |
        (halt_cfg_in.ovf_ie & ~halt_cfg_in.clk_sel_hi & halt_cfg_in.clk_sel_lo);
    wire plain_halt = ~act_halt_en & ~halt_cfg_in.auto_wake_enable;
    // active-halt suppresses the watchdog reset
    wire wdg_kill = halt_cfg_in.watchdog_on & ~halt_cfg_in.watchdog_in_halt_opt
        & ~act_halt_en;
    wire halt_go = cpu_evt_in.halt_instr & (mode_reg == MODE_RUN);
    wire [12:0] stab_len = clk_ctrl_reg[`CLK_CTRL_LONG_BIT] ?
        13'(`STAB_LONG_CYC) : 13'(`STAB_SHORT_CYC);

    // ==========================================================
    // mode sequencer
    always_comb
    begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_RUN:
            begin
                if (cpu_evt_in.wait_instr)
                    mode_next = MODE_WAIT;
                else if (halt_go && !wdg_kill && act_halt_en)
                    mode_next = MODE_ACT_HALT;
                else if (halt_go && !wdg_kill && plain_halt)
                    mode_next = MODE_HALT;
            end
            MODE_WAIT:
                if (any_irq)
                    mode_next = MODE_RUN;
            MODE_HALT:
                if (halt_wake)
                    mode_next = MODE_STAB;
            MODE_ACT_HALT:
                if (halt_wake)
                    mode_next = MODE_RUN;
            MODE_STAB:
                if (stab_cnt_reg == 13'h0001)
                    mode_next = MODE_RUN;
            default:
                mode_next = MODE_RUN;
        endcase
    end

    // reset exits land in stabilisation; the reset source is out of scope so
    // the delay after a system reset is the caller's, this block starts in run
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            mode_reg <= MODE_RUN;
            stab_cnt_reg <= 13'h0000;
        end
        else
        begin
            mode_reg <= mode_next;
            if (mode_reg == MODE_HALT && halt_wake)
                stab_cnt_reg <= stab_len;
            else if (stab_cnt_reg != 13'h0000)
                stab_cnt_reg <= stab_cnt_reg - 13'h0001;
        end
    end

    // watchdog reset pulse on a forbidden halt
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
            wdg_rst_reg <= 1'b0;
        else
            wdg_rst_reg <= halt_go & wdg_kill;
    end
    assign watchdog_reset_out = wdg_rst_reg;

    // ==========================================================
    // global interrupt mask (set after reset: all interrupts disabled)
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            mask_reg <= 1'b1;
            mask_saved_reg <= 1'b1;
        end
        else if (mode_reg == MODE_RUN && mode_next != MODE_RUN)
            mask_reg <= 1'b0;
        else if (cpu_evt_in.irq_enter)
        begin
            mask_saved_reg <= mask_reg;
            mask_reg <= 1'b1;
        end
        else if (cpu_evt_in.irq_return)
            mask_reg <= mask_saved_reg;
    end
    assign irq_mask_out = mask_reg;

    // ==========================================================
    // register writes
    wire wr_sense = reg_req_in.wr & (reg_req_in.addr[3:0] == `ADDR_SENSE);
    wire wr_sel = reg_req_in.wr & (reg_req_in.addr[3:0] == `ADDR_PIN_SEL);
    wire wr_clk = reg_req_in.wr & (reg_req_in.addr[3:0] == `ADDR_CLK_CTRL);
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            sense_reg <= `RESET_SENSE;
            pin_sel_reg <= `RESET_PIN_SEL;
            clk_ctrl_reg <= 2'(`RESET_CLK_CTRL);
        end
        else
        begin
            if (wr_sense && mask_reg)
                sense_reg <= reg_req_in.wdata;
            if (wr_sel)
                pin_sel_reg <= reg_req_in.wdata;
            if (wr_clk)
                clk_ctrl_reg <= reg_req_in.wdata[1:0];
        end
    end

    // read mux: data valid in the cycle after the read strobe
    wire [7:0] rd_mux =
        (reg_req_in.addr[3:0] == `ADDR_SENSE) ? sense_reg :
        (reg_req_in.addr[3:0] == `ADDR_PIN_SEL) ? pin_sel_reg :
        (reg_req_in.addr[3:0] == `ADDR_CLK_CTRL) ? {6'h00, clk_ctrl_reg} :
        (reg_req_in.addr[3:0] == `ADDR_STATUS) ? {1'b0, mode_reg, req_reg} :
        8'h00;
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
            rdata_reg <= 8'h00;
        else if (reg_req_in.rd)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 8'h00;
    end
    assign reg_rdata_out = rdata_reg;

    // ==========================================================
    // clock enables: slow mode divides by 32
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
            slow_cnt_reg <= 5'h00;
        else
            slow_cnt_reg <= slow_cnt_reg + 5'h01;
    end
    wire slow_tick = (slow_cnt_reg == 5'(`SLOW_DIV - 1));
    wire rate_en = clk_ctrl_reg[`CLK_CTRL_SLOW_BIT] ? slow_tick : 1'b1;
    wire in_halt = (mode_reg == MODE_HALT);
    wire in_ahalt = (mode_reg == MODE_ACT_HALT);
    wire in_stab = (mode_reg == MODE_STAB);
    // wait keeps peripherals at the current rate: slow plus wait is slow-wait
    assign cpu_run_out = (mode_reg == MODE_RUN);
    assign cpu_clk_en_out = cpu_run_out & rate_en;
    assign periph_clk_en_out = (cpu_run_out | (mode_reg == MODE_WAIT)) & rate_en;
    assign osc_on_out = ~in_halt;
    assign timer_clk_en_out = (cpu_run_out | (mode_reg == MODE_WAIT) | in_ahalt) & rate_en;
    assign mode_out = mode_reg;

    // ==========================================================
    // checks
    a_sense_locked: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (wr_sense && !mask_reg) |=> $stable(sense_reg))
        else $error("sensitivity changed while mask clear");
    a_halt_mask_clr: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (mode_reg == MODE_RUN && mode_next == MODE_HALT) |=> !mask_reg)
        else $error("mask not cleared on halt entry");
    a_halt_osc_off: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        in_halt |-> (!osc_on_out && !periph_clk_en_out && !cpu_clk_en_out))
        else $error("clocks running in halt");
    a_halt_exit_src: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (in_halt && !halt_wake) |=> in_halt)
        else $error("halt left without wake source");
    a_stab_delay: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (in_halt && halt_wake && !clk_ctrl_reg[`CLK_CTRL_LONG_BIT])
        |=> in_stab [*8] ##249 cpu_run_out)
        else $error("short stabilisation delay wrong");
    a_ahalt_fast: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (in_ahalt && halt_wake) |=> cpu_run_out)
        else $error("active-halt exit delayed");
    a_ahalt_no_wdg: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (halt_go && act_halt_en) |=> !watchdog_reset_out)
        else $error("watchdog reset in active-halt");
    a_wait_wake: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (mode_reg == MODE_WAIT && any_irq) |=> cpu_run_out ##0 !mask_reg)
        else $error("wait not left on interrupt");
    a_pb4_no_wake: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (in_halt && pb4_blocked && ext_req == 4'h4 && !other_halt_irq_in) |=> in_halt)
        else $error("pin 4 woke halt");
    a_mask_gate: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        mask_reg |-> (ext_irq_req_out == 4'h0))
        else $error("request passed while masked");

    // ==========================================================
    // checks on clock gating, timer choice and request bookkeeping
    // active-halt keeps oscillator and timer, cpu and peripherals stop
    a_ahalt_clocks: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        in_ahalt |-> (osc_on_out && !periph_clk_en_out && !cpu_clk_en_out))
        else $error("wrong clocks in active-halt");
    // timer choice must land in active-halt, not plain halt
    a_ahalt_entry: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (halt_go && act_halt_en && !wdg_kill && !cpu_evt_in.wait_instr) |=> in_ahalt)
        else $error("active-halt not entered");
    // a forbidden halt gives a watchdog pulse and no mode change
    a_wdg_pulse: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (halt_go && wdg_kill) |=> (watchdog_reset_out && cpu_run_out))
        else $error("watchdog pulse missing");
    // between slow ticks the cpu enable must stay low
    a_slow_gap: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (clk_ctrl_reg[`CLK_CTRL_SLOW_BIT] && !slow_tick) |-> !cpu_clk_en_out)
        else $error("cpu enabled between slow ticks");
    // service entry clears latched edges when no new edge arrives
    a_edge_clear: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (cpu_evt_in.irq_enter && edge_hit == 4'h0) |=> (req_reg == 4'h0))
        else $error("edge request not cleared");
    // service entry masks further interrupts
    a_enter_mask: assert property (@(posedge clk_sys_in) disable iff (!resetn_in)
        (cpu_evt_in.irq_enter && mode_next == mode_reg) |=> mask_reg)
        else $error("mask not set on service entry");

endmodule : power_mode_and_ext_irq_ctrl

/* rtl/pwr_mode_defs.svh */
// constants for the power mode and external interrupt controller
// assumes a 100 MHz system clock and a plain strobe register port
//
// Overview of operation
// - sensitivity register holds four 2-bit fields, line 3 at top, line 0 at bottom
// - field codes: 00 fall+low, 01 rise, 10 fall, 11 both edges
// - sensitivity register writable only while the global interrupt mask is set
// - line 3 selects port B pin 0, 1 or 2; reset picks pin 0
// - line 2 selects port B pin 3 to 6; reset picks pin 3
// - line 2 routed to port B pin 4 cannot wake from halt
// - line 1 selects port A pin 4 to 7; reset picks pin 7
// - line 0 selects port A pin 0 to 3; reset picks pin 0
// - reset enters run mode with master clock from the oscillator
// - slow select divides clock by 32; wait in slow gives slow-wait
// - wait stops cpu, keeps peripherals, clears mask, leaves on any interrupt
// - servicing pushes condition codes, sets mask, restores it on pop
// - halt instruction enters plain halt only without active-halt and auto wake
// - halt is left only by reset or a halt-capable interrupt
// - halt exit restarts oscillator, waits 256 or 4096 cycles, then services
// - entering halt or active-halt forces mask clear; pending request wakes at once
// - halt stops oscillator and all internal and peripheral clocks
// - watchdog enabled at halt may reset instead, per option bit
// - active-halt chosen by base-1 enable or overflow enable with clock select 01
// - active-halt reset exit delays; interrupt exit services immediately
// - active-halt keeps only oscillator and selected timer running
// - with active-halt enabled, halt never gives a watchdog reset
// - maskable interrupts serviced only with mask clear; others stay latched
// - edge requests latched and cleared on entering the service routine

`ifndef PWR_MODE_DEFS_SVH
`define PWR_MODE_DEFS_SVH

// ==========================================================
// register map
`define ADDR_SENSE 4'h0
`define ADDR_PIN_SEL 4'h1
`define ADDR_CLK_CTRL 4'h2
`define ADDR_STATUS 4'h3
`define RESET_SENSE 8'h00
`define RESET_PIN_SEL 8'h0C
`define RESET_CLK_CTRL 8'h00
`define CLK_CTRL_SLOW_BIT 0
`define CLK_CTRL_LONG_BIT 1

// ==========================================================
// timing
`define SLOW_DIV 32
`define STAB_SHORT_CYC 256
`define STAB_LONG_CYC 4096

`endif

/* rtl/pwr_mode_pkg.sv */
// types for the power mode and external interrupt controller
// assumes the constants header is included by users
package pwr_mode_pkg;
    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_WAIT,
        MODE_HALT,
        MODE_ACT_HALT,
        MODE_STAB
    } pwr_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic wait_instr;
        logic halt_instr;
        logic irq_enter;
        logic irq_return;
    } cpu_evt_t;

    typedef struct packed {
        logic base1_ie;
        logic ovf_ie;
        logic clk_sel_hi;
        logic clk_sel_lo;
        logic auto_wake_enable;
        logic watchdog_on;
        logic watchdog_in_halt_opt;
    } halt_cfg_t;
endpackage : pwr_mode_pkg

/* sim/ext_pin_model.sv */
// partner model: the port pins that carry the external interrupt lines
// assumes its tasks are called from processes timed on clk_sys_in
`timescale 1ns/100ps

module ext_pin_model
(
    input wire logic clk_sys_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_b_out
);
    // ==========================================================
    // pins
    // idle high, as an input with pull-up would sit
    initial
    begin
        port_a_out = 8'hFF;
        port_b_out = 8'hFF;
    end

    // one pin moves just after an edge, so the sync flops see a clean step
    task automatic drive_pin(input logic on_b, input logic [2:0] idx, input logic val);
        @(posedge clk_sys_in);
        if (on_b)
            port_b_out[idx] <= val;
        else
            port_a_out[idx] <= val;
    endtask : drive_pin
endmodule : ext_pin_model

/* sim/tb_top.sv */
// self-checking bench for the power mode and external interrupt controller
// assumes the design package and header are compiled first
`timescale 1ns/100ps
`include "pwr_mode_defs.svh"

module tb_top
    import pwr_mode_pkg::*;
();
    logic clk_sys_in;
    logic resetn_in;
    reg_req_t reg_req;
    cpu_evt_t cpu_evt;
    halt_cfg_t halt_cfg;
    logic other_irq;
    logic other_halt_irq;
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic [7:0] rdata;
    logic irq_mask;
    logic [3:0] ext_req;
    logic cpu_en;
    logic cpu_run;
    logic periph_en;
    logic timer_en;
    logic osc_on;
    logic wdg_rst;
    pwr_mode_t mode;
    logic rd_d;
    logic [7:0] sel;
    logic [7:0] exp_q[$];
    int miscompares;
    int num_checks;
    int n;
    // halt entry table: config, resulting mode, {osc_on, watchdog pulse}
    logic [6:0] cfgs[4] = '{7'b1000010, 7'b0101010, 7'b0000100, 7'b0000010};
    pwr_mode_t md[4] = '{MODE_ACT_HALT, MODE_ACT_HALT, MODE_RUN, MODE_RUN};
    logic [1:0] ow[4] = '{2'b10, 2'b10, 2'b10, 2'b11};

    // ==========================================================
    // design and partner
    power_mode_and_ext_irq_ctrl power_mode_and_ext_irq_ctrl_inst (.clk_sys_in(clk_sys_in),
        .resetn_in(resetn_in), .reg_req_in(reg_req), .reg_rdata_out(rdata),
        .cpu_evt_in(cpu_evt), .halt_cfg_in(halt_cfg), .other_irq_in(other_irq),
        .other_halt_irq_in(other_halt_irq), .port_a_in(port_a), .port_b_in(port_b),
        .irq_mask_out(irq_mask), .ext_irq_req_out(ext_req), .cpu_run_out(cpu_run),
        .periph_clk_en_out(periph_en), .osc_on_out(osc_on), .timer_clk_en_out(timer_en),
        .cpu_clk_en_out(cpu_en), .watchdog_reset_out(wdg_rst), .mode_out(mode));
    ext_pin_model ext_pin_model_inst (.clk_sys_in(clk_sys_in), .port_a_out(port_a),
        .port_b_out(port_b));

    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // ==========================================================
    // checking
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys_in)
    begin
        if (rd_d)
            chk(rdata, exp_q.pop_front());
        rd_d <= reg_req.rd;
    end

    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        reg_req <= '{addr: {4'h0, a}, wdata: d, wr: w, rd: !w};
        @(posedge clk_sys_in);
        reg_req <= '0;
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask : rd

    task automatic evt(input cpu_evt_t e);
        @(posedge clk_sys_in);
        cpu_evt <= e;
        @(posedge clk_sys_in);
        cpu_evt <= '0;
        @(negedge clk_sys_in);
    endtask : evt

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    // a hang is cut well past the few hundred cycles the tests need
    initial
    begin
        #200000;
        miscompares++;
        wrap_up();
    end

    // ==========================================================
    // tests
    initial
    begin
        resetn_in = 1'b0;
        reg_req = '0;
        cpu_evt = '0;
        halt_cfg = '0;
        other_irq = 1'b0;
        other_halt_irq = 1'b0;
        rd_d = 1'b0;
        n = $urandom(73);
        repeat (8) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        rd(`ADDR_SENSE, `RESET_SENSE);
        rd(`ADDR_PIN_SEL, `RESET_PIN_SEL);
        rd(`ADDR_CLK_CTRL, `RESET_CLK_CTRL);
        rd(4'hF, 8'h00);
        rd(`ADDR_STATUS, {1'b0, MODE_RUN, 4'h0});
        chk(irq_mask, 16'h1);
        $display("test reset done");
        // random line 0 pin; codes 01, 10 and 11 each see one fall then one rise
        sel = 8'($urandom);
        bus(1'b1, `ADDR_PIN_SEL, sel);
        rd(`ADDR_PIN_SEL, sel);
        for (int c = 1; c < 4; c++)
        begin
            bus(1'b1, `ADDR_SENSE, 8'(c));
            rd(`ADDR_SENSE, 8'(c));
            ext_pin_model_inst.drive_pin(1'b0, {1'b0, sel[1:0]}, 1'b0);
            repeat (5) @(posedge clk_sys_in);
            rd(`ADDR_STATUS, {7'h0, c[1]});
            chk(ext_req, 16'h0);
            evt(4'b0010);
            evt(4'b0001);
            ext_pin_model_inst.drive_pin(1'b0, {1'b0, sel[1:0]}, 1'b1);
            repeat (5) @(posedge clk_sys_in);
            rd(`ADDR_STATUS, {7'h0, c[0]});
            evt(4'b0010);
            evt(4'b0001);
        end
        $display("test edge sense done");
        // plain halt: port B pin 4 must not wake, line 0 pin must
        bus(1'b1, `ADDR_PIN_SEL, 8'h10);
        bus(1'b1, `ADDR_SENSE, 8'h22);
        evt(4'b0100);
        chk({mode, irq_mask, osc_on}, {MODE_HALT, 2'b00});
        chk({cpu_run, periph_en, timer_en}, 16'h0);
        ext_pin_model_inst.drive_pin(1'b1, 3'd4, 1'b0);
        repeat (8) @(posedge clk_sys_in);
        chk(mode, MODE_HALT);
        ext_pin_model_inst.drive_pin(1'b0, 3'd0, 1'b0);
        n = 0;
        while (mode !== MODE_STAB && n < 10)
        begin
            @(negedge clk_sys_in);
            n++;
        end
        chk(mode, MODE_STAB);
        n = 0;
        while (mode === MODE_STAB && n < 5000)
        begin
            n++;
            @(negedge clk_sys_in);
        end
        chk(16'(n), 16'(`STAB_SHORT_CYC));
        chk({mode, osc_on, ext_req[0]}, {MODE_RUN, 2'b11});
        ext_pin_model_inst.drive_pin(1'b1, 3'd4, 1'b1);
        ext_pin_model_inst.drive_pin(1'b0, 3'd0, 1'b1);
        evt(4'b0010);
        chk({irq_mask, ext_req}, 16'h10);
        evt(4'b0001);
        chk(irq_mask, 16'h0);
        $display("test halt done");
        // wait: sense write refused with mask clear, other_irq wakes
        evt(4'b1000);
        chk({mode, irq_mask}, {MODE_WAIT, 1'b0});
        bus(1'b1, `ADDR_SENSE, 8'hFF);
        rd(`ADDR_SENSE, 8'h22);
        other_irq <= 1'b1;
        repeat (3) @(negedge clk_sys_in);
        chk(mode, MODE_RUN);
        other_irq <= 1'b0;
        $display("test wait done");
        // halt choice by timer and wake config, watchdog interplay
        for (int i = 0; i < 4; i++)
        begin
            halt_cfg <= cfgs[i];
            evt(4'b0100);
            chk({mode, osc_on, wdg_rst}, {md[i], ow[i]});
            chk({cpu_run, periph_en, timer_en}, (md[i] == MODE_RUN) ? 16'h7 : 16'h1);
            @(posedge clk_sys_in);
            other_halt_irq <= 1'b1;
            @(posedge clk_sys_in);
            other_halt_irq <= 1'b0;
            @(negedge clk_sys_in);
            chk(mode, MODE_RUN);
        end
        halt_cfg <= '0;
        $display("test active halt done");
        // slow clock: two enable pulses in 64 cycles
        bus(1'b1, `ADDR_CLK_CTRL, 8'h01);
        n = 0;
        repeat (64)
        begin
            @(negedge clk_sys_in);
            n += cpu_en;
        end
        chk(16'(n), 16'(64 / `SLOW_DIV));
        bus(1'b1, `ADDR_CLK_CTRL, 8'h00);
        $display("test slow done");
        repeat (4) @(posedge clk_sys_in);
        wrap_up();
    end
endmodule : tb_top
